//--- ptc_regs.sv
/*
 * Protection and trim configuration register bank, offsets 0x4c to 0x53.
 * Assumes an upstream serial slave presents one-cycle write and read
 * strobes with an 8-bit offset, and that comparator results are
 * synchronous to clk.
 */
// Function
// - Zero-cross config bit 2 selects two-level or mid-level switch drive.
// - Zero-cross config bit 1 controls threshold reset, default 0.
// - Zero-cross config bit 0 set disables zero-cross detection.
// - Trim bits 5:0 give a signed threshold offset, 0.6 mV per step.
// - Gate bits 5:1 hold minimum output threshold, 35 mV steps from 0.215 V.
// - Per-phase limiting is suppressed while output is below the minimum.
// - Gate bit 0 set activates the gating, cleared leaves it inactive.
// - Overvoltage bits 2:0 offset the 600 mV trip level by 50 mV steps.
// - Overvoltage code 100 clamps the trip level to 2.0 V absolute.
// - Undervoltage bits 2:0 offset the -500 mV trip level by 50 mV steps.
// - Thermal register holds 8-bit warning threshold, reset 0xff.
// - A rising write of clear bit 0 resets the overcurrent status.
// - The clear register stays writable while the write lock is set.
// - Auxiliary bit 3 enables the ultrasonic timer.
// - Auxiliary bit 2 selects fuse or serial-bus configuration settings.
// - Auxiliary bit 1 selects the current-limit trigger criterion.
// - The host changes registers at run time; new values apply at once.
`default_nettype none

module ptc_regs
    import ptc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Register port from the serial slave.
    input wire ptc_req_type req,
    input wire logic read,
    input wire logic write_lock,
    output logic [7:0] rdata,
    // Analog comparator results and monitor reading.
    input wire logic output_below_min,
    input wire logic [7:0] thermal_monitor,
    // Configuration outputs.
    output ptc_zc_type zero_cross_detect,
    output logic [4:0] min_output_limit_gate,
    output logic min_output_gate_enable,
    output logic limit_suppress,
    output ptc_prot_type protection,
    output logic status_clear,
    output logic ultrasonic_timer_enable,
    output logic bus_settings_select,
    output logic limit_trigger_select
);

    ptc_state_type state;
    ptc_state_type next_state;
    logic wr;

    // The lock bars ordinary registers but never the clear register.
    assign wr = req.write && !write_lock;

    always_comb begin
        next_state = state;
        next_state.status_clear = 1'b0;
        if (wr && req.addr == ZC_CONFIG_ADDR) begin
            next_state.zc_config = req.data & ZC_CONFIG_MASK;
        end else if (wr && req.addr == ZC_TRIM_ADDR) begin
            next_state.zc_trim = req.data & ZC_TRIM_MASK;
        end else if (wr && req.addr == GATE_ADDR) begin
            next_state.gate = req.data & GATE_MASK;
        end else if (wr && req.addr == OV_ADDR) begin
            next_state.ov = req.data & OV_MASK;
        end else if (wr && req.addr == UV_ADDR) begin
            next_state.uv = req.data & UV_MASK;
        end else if (wr && req.addr == THERM_ADDR) begin
            next_state.therm = req.data & THERM_MASK;
        end else if (req.write && req.addr == CLEAR_ADDR) begin
            next_state.clear = req.data & CLEAR_MASK;
            next_state.status_clear = req.data[CLEAR_BIT] && !state.clear[CLEAR_BIT];
        end else if (wr && req.addr == AUX_ADDR) begin
            next_state.aux = req.data & AUX_MASK;
        end
        // Decoded flags are registered so that every output leaves a flip-flop.
        next_state.detect_enable = !next_state.zc_config[ZC_DISABLE_BIT];
        next_state.overvoltage_clamp = next_state.ov[2:0] == OV_CLAMP_CODE;
        next_state.undervoltage_protection = next_state.uv[2:0] != UV_OFF_CODE;
        next_state.rdata = 8'h00;
        if (read && req.addr == ZC_CONFIG_ADDR) begin
            next_state.rdata = state.zc_config;
        end else if (read && req.addr == ZC_TRIM_ADDR) begin
            next_state.rdata = state.zc_trim;
        end else if (read && req.addr == GATE_ADDR) begin
            next_state.rdata = state.gate;
        end else if (read && req.addr == OV_ADDR) begin
            next_state.rdata = state.ov;
        end else if (read && req.addr == UV_ADDR) begin
            next_state.rdata = state.uv;
        end else if (read && req.addr == THERM_ADDR) begin
            next_state.rdata = state.therm;
        end else if (read && req.addr == CLEAR_ADDR) begin
            next_state.rdata = state.clear;
        end else if (read && req.addr == AUX_ADDR) begin
            next_state.rdata = state.aux;
        end
        // Gating only acts when enabled, so a cleared enable never masks a limit.
        next_state.limit_suppress = state.gate[GATE_ENABLE_BIT] && output_below_min;
        next_state.thermal_warning = thermal_monitor >= state.therm;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state.zc_config <= ZC_CONFIG_RESET;
            state.zc_trim <= ZC_TRIM_RESET;
            state.gate <= GATE_RESET;
            state.ov <= OV_RESET;
            state.uv <= UV_RESET;
            state.therm <= THERM_RESET;
            state.clear <= CLEAR_RESET;
            state.aux <= AUX_RESET;
            state.rdata <= 8'h00;
            state.status_clear <= 1'b0;
            state.limit_suppress <= 1'b0;
            state.thermal_warning <= 1'b0;
            state.detect_enable <= !ZC_CONFIG_RESET[ZC_DISABLE_BIT];
            state.overvoltage_clamp <= OV_RESET[2:0] == OV_CLAMP_CODE;
            state.undervoltage_protection <= UV_RESET[2:0] != UV_OFF_CODE;
        end else begin
            state <= next_state;
        end
    end

    // Outputs are straight register bits or fixed slices of them.
    assign rdata = state.rdata;
    assign zero_cross_detect.mid_level_drive = state.zc_config[ZC_MID_LEVEL_BIT];
    assign zero_cross_detect.threshold_reset = state.zc_config[ZC_RESET_BIT];
    assign zero_cross_detect.detect_enable = state.detect_enable;
    assign zero_cross_detect.trim_code = state.zc_trim[5:0];
    assign min_output_limit_gate = state.gate[GATE_CODE_LSB +: 5];
    assign min_output_gate_enable = state.gate[GATE_ENABLE_BIT];
    assign limit_suppress = state.limit_suppress;
    assign protection.overvoltage_clamp = state.overvoltage_clamp;
    assign protection.overvoltage_trip_code = state.ov[2:0];
    assign protection.undervoltage_protection = state.undervoltage_protection;
    assign protection.undervoltage_trip_code = state.uv[2:0];
    assign protection.thermal_threshold = state.therm;
    assign protection.thermal_warning = state.thermal_warning;
    assign status_clear = state.status_clear;
    assign ultrasonic_timer_enable = state.aux[AUX_TIMER_BIT];
    assign bus_settings_select = state.aux[AUX_SOURCE_BIT];
    assign limit_trigger_select = state.aux[AUX_TRIGGER_BIT];

endmodule

`default_nettype wire

//--- ptc_pkg.sv
/*
 * Package for the protection and trim configuration register bank.
 * Holds register offsets, field positions, reset values and codes.
 * Assumes an 8-bit register port decoded by an upstream serial slave.
 */
`default_nettype none

package ptc_pkg;

    // Register offsets.
    localparam logic [7:0] ZC_CONFIG_ADDR = 8'h4c;
    localparam logic [7:0] ZC_TRIM_ADDR = 8'h4d;
    localparam logic [7:0] GATE_ADDR = 8'h4e;
    localparam logic [7:0] OV_ADDR = 8'h4f;
    localparam logic [7:0] UV_ADDR = 8'h50;
    localparam logic [7:0] THERM_ADDR = 8'h51;
    localparam logic [7:0] CLEAR_ADDR = 8'h52;
    localparam logic [7:0] AUX_ADDR = 8'h53;

    // Writable bit masks; all other bits are reserved.
    localparam logic [7:0] ZC_CONFIG_MASK = 8'h07;
    localparam logic [7:0] ZC_TRIM_MASK = 8'h3f;
    localparam logic [7:0] GATE_MASK = 8'h3f;
    localparam logic [7:0] OV_MASK = 8'h07;
    localparam logic [7:0] UV_MASK = 8'h07;
    localparam logic [7:0] THERM_MASK = 8'hff;
    localparam logic [7:0] CLEAR_MASK = 8'h01;
    localparam logic [7:0] AUX_MASK = 8'h0e;

    // Reset values.
    localparam logic [7:0] ZC_CONFIG_RESET = 8'h00;
    localparam logic [7:0] ZC_TRIM_RESET = 8'h00;
    localparam logic [7:0] GATE_RESET = 8'h00;
    localparam logic [7:0] OV_RESET = 8'h00;
    localparam logic [7:0] UV_RESET = 8'h00;
    localparam logic [7:0] THERM_RESET = 8'hff;
    localparam logic [7:0] CLEAR_RESET = 8'h00;
    localparam logic [7:0] AUX_RESET = 8'h00;

    // Field positions.
    localparam int ZC_MID_LEVEL_BIT = 2;
    localparam int ZC_RESET_BIT = 1;
    localparam int ZC_DISABLE_BIT = 0;
    localparam int GATE_ENABLE_BIT = 0;
    localparam int GATE_CODE_LSB = 1;
    localparam int CLEAR_BIT = 0;
    localparam int AUX_TIMER_BIT = 3;
    localparam int AUX_SOURCE_BIT = 2;
    localparam int AUX_TRIGGER_BIT = 1;

    // Special trip codes.
    localparam logic [2:0] OV_CLAMP_CODE = 3'h4;
    localparam logic [2:0] UV_OFF_CODE = 3'h4;

    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] data;
    } ptc_req_type;

    typedef struct packed {
        logic mid_level_drive;
        logic threshold_reset;
        logic detect_enable;
        logic [5:0] trim_code;
    } ptc_zc_type;

    typedef struct packed {
        logic overvoltage_clamp;
        logic [2:0] overvoltage_trip_code;
        logic undervoltage_protection;
        logic [2:0] undervoltage_trip_code;
        logic [7:0] thermal_threshold;
        logic thermal_warning;
    } ptc_prot_type;

    typedef struct packed {
        logic [7:0] zc_config;
        logic [7:0] zc_trim;
        logic [7:0] gate;
        logic [7:0] ov;
        logic [7:0] uv;
        logic [7:0] therm;
        logic [7:0] clear;
        logic [7:0] aux;
        logic [7:0] rdata;
        logic status_clear;
        logic limit_suppress;
        logic thermal_warning;
        logic detect_enable;
        logic overvoltage_clamp;
        logic undervoltage_protection;
    } ptc_state_type;

endpackage

`default_nettype wire

//--- ptc_regs_properties.sv
/* Checker bound to the register bank top module.
   Assumes one clock with a synchronous active-high reset. */
`default_nettype none
module ptc_regs_properties
    import ptc_pkg::*;
(
    // Clock, reset and register port.
    input wire logic clk,
    input wire logic reset,
    input wire ptc_req_type req,
    input wire logic read,
    input wire logic write_lock,
    input wire logic [7:0] rdata,
    // Watched levels and outputs.
    input wire logic output_below_min,
    input wire logic [7:0] thermal_monitor,
    input wire logic min_output_gate_enable,
    input wire logic limit_suppress,
    input wire ptc_prot_type protection,
    input wire logic status_clear
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_suppress_gate: assert property (!$past(reset) |-> limit_suppress ==
        $past(min_output_gate_enable && output_below_min)) else $error("suppress wrong");
    a_clear_cause: assert property (status_clear |->
        $past(req.write && req.addr == CLEAR_ADDR && req.data[CLEAR_BIT])) else $error("stray");
    a_clear_single: assert property (status_clear |=> !status_clear)
        else $error("clear pulse too long");
    a_rdata_zero: assert property (
        !$past(read && req.addr inside {[ZC_CONFIG_ADDR:AUX_ADDR]}) |-> rdata == 8'h00)
        else $error("rdata not zero");
    a_ov_clamp: assert property (protection.overvoltage_clamp ==
        (protection.overvoltage_trip_code == OV_CLAMP_CODE)) else $error("clamp wrong");
    a_uv_off: assert property (protection.undervoltage_protection ==
        (protection.undervoltage_trip_code != UV_OFF_CODE)) else $error("uv enable wrong");
    a_locked_hold: assert property (write_lock && req.write && req.addr != CLEAR_ADDR
        |=> $stable({protection.overvoltage_trip_code, protection.undervoltage_trip_code,
        protection.thermal_threshold})) else $error("locked write took effect");
    a_ov_write: assert property (req.write && !write_lock && req.addr == OV_ADDR |=>
        protection.overvoltage_trip_code == $past(req.data[2:0])) else $error("ov code lost");
    a_therm_warn: assert property (!$past(reset) |-> protection.thermal_warning ==
        ($past(thermal_monitor) >= $past(protection.thermal_threshold))) else $error("warn");
    // A clear under lock is the case most likely to be gated off by mistake.
    c_clear: cover property (write_lock && status_clear);
    c_suppress: cover property (limit_suppress);
    c_clamp: cover property (protection.overvoltage_clamp);
endmodule
bind ptc_regs ptc_regs_properties ptc_regs_properties_inst(.clk, .reset, .req, .read,
    .write_lock, .rdata, .output_below_min, .thermal_monitor, .min_output_gate_enable,
    .limit_suppress, .protection, .status_clear);
`default_nettype wire

//--- ptc_host.sv
/* Host model issuing single-byte register writes and reads.
   Assumes the bench calls op; requests launch at falling edges. */
`default_nettype none
module ptc_host
    import ptc_pkg::*;
(
    // Clock and register port.
    input wire logic clk,
    output ptc_req_type req,
    output logic read,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {req, read} = '0;
    // Released lines show inverted data so stale bytes cannot pass.
    task automatic op(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(negedge clk);
        req = '{w, a, d};
        read = !w;
        @(negedge clk);
        q = rdata;
        req = '{1'b0, ~a, ~d};
        read = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- ptc_regs_bench.sv
/* Self-checking bench for the register bank.
   Assumes the package, design, host model and checker are compiled first. */
`default_nettype none
module ptc_regs_bench;
    import ptc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset = 1, write_lock = 0, output_below_min = 0, read, status_clear;
    logic [7:0] thermal_monitor = 8'h00, rdata, q;
    logic [15:0] lfsr = 16'hcfda;
    logic aux_t, aux_b, aux_l;
    ptc_req_type req;
    ptc_prot_type prot;
    ptc_zc_type zc;
    logic [4:0] gate_code;
    logic gate_en;
    logic [7:0] rv[8];
    int mismatches = 0, checks = 0, cycles = 0, pulses = 0;
    logic [7:0] m[8] = '{ZC_CONFIG_MASK, ZC_TRIM_MASK, GATE_MASK, OV_MASK, UV_MASK,
        THERM_MASK, CLEAR_MASK, AUX_MASK};
    logic [7:0] sh[8] = '{ZC_CONFIG_RESET, ZC_TRIM_RESET, GATE_RESET, OV_RESET, UV_RESET,
        THERM_RESET, CLEAR_RESET, AUX_RESET};
    always #2 clk = ~clk;
    ptc_regs ptc_regs_inst(.clk, .reset, .req, .read, .write_lock, .rdata, .output_below_min,
        .thermal_monitor, .zero_cross_detect(zc), .min_output_limit_gate(gate_code),
        .min_output_gate_enable(gate_en), .limit_suppress(), .protection(prot), .status_clear,
        .ultrasonic_timer_enable(aux_t), .bus_settings_select(aux_b),
        .limit_trigger_select(aux_l));
    ptc_host ptc_host_inst(.clk, .req, .read, .rdata);
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] expect_of(input int i, input logic [7:0] d);
        return d & m[i];
    endfunction
    task automatic cmp(input string what, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check_defaults;
        for (int k = 0; k < 10; k++) begin
            ptc_host_inst.op(0, 8'(8'h4b + k), 8'h00, q);
            cmp("reset or unmapped", (k % 9) ? rv[k - 1] : 8'h00, q);
        end
        cmp("reset flags", 8'h03,
            {5'h0, prot.overvoltage_clamp, zc.detect_enable, prot.undervoltage_protection});
        sh = rv;
        $display("reset test done");
    endtask
    always @(negedge clk) begin
        lfsr <= step(lfsr);
        output_below_min <= lfsr[0];
        thermal_monitor <= lfsr[15:8];
    end
    // Pulses are counted at the falling edge, where the registered output is settled.
    always @(negedge clk) begin
        cycles++;
        pulses += (status_clear === 1'b1);
        if (cycles == 2000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        int i;
        int expp;
        logic [7:0] d;
        expp = 0;
        rv = sh;
        repeat (16) @(posedge clk);
        @(negedge clk) reset = 0;
        check_defaults();
        // Bits 2:0 sweep all eight codes on every register; higher bits stay random.
        for (int n = 0; n < 64; n++) begin
            i = n % 8;
            d = 8'(n / 8) | (lfsr[7:0] & 8'hf8);
            if (i == 6 && !sh[6][0] && d[0]) expp++;
            ptc_host_inst.op(1, 8'(ZC_CONFIG_ADDR + i), d, q);
            sh[i] = expect_of(i, d);
            ptc_host_inst.op(0, 8'(ZC_CONFIG_ADDR + i), 8'h00, q);
            cmp("readback", sh[i], q);
            if (i == 0) begin
                cmp("zero cross", {5'h0, d[2:1], !d[0]},
                    {5'h0, zc.mid_level_drive, zc.threshold_reset, zc.detect_enable});
            end else if (i == 1) begin
                cmp("trim", {2'h0, d[5:0]}, {2'h0, zc.trim_code});
            end else if (i == 2) begin
                cmp("gate", {2'h0, d[5:0]}, {2'h0, gate_code, gate_en});
            end else if (i == 3) begin
                cmp("overvoltage", {4'h0, d[2:0] == OV_CLAMP_CODE, d[2:0]},
                    {4'h0, prot.overvoltage_clamp, prot.overvoltage_trip_code});
            end else if (i == 4) begin
                cmp("undervoltage", {4'h0, d[2:0] != UV_OFF_CODE, d[2:0]},
                    {4'h0, prot.undervoltage_protection, prot.undervoltage_trip_code});
            end else if (i == 5) begin
                cmp("thermal", d, prot.thermal_threshold);
            end else if (i == 7) begin
                cmp("aux", {5'h0, d[3:1]}, {5'h0, aux_t, aux_b, aux_l});
            end
        end
        $display("readback test done");
        write_lock = 1;
        ptc_host_inst.op(1, CLEAR_ADDR, 8'h00, q);
        sh[6] = 8'h00;
        for (i = 0; i < 8; i++) begin
            if (i == 6) expp++;
            ptc_host_inst.op(1, 8'(ZC_CONFIG_ADDR + i), ~sh[i] | 8'h01, q);
            if (i == 6) sh[6] = 8'h01;
            ptc_host_inst.op(0, 8'(ZC_CONFIG_ADDR + i), 8'h00, q);
            cmp("locked", sh[i], q);
        end
        ptc_host_inst.op(1, CLEAR_ADDR, 8'h01, q);
        write_lock = 0;
        // A stray pulse from the last write must be counted before the tally is compared.
        repeat (2) @(negedge clk);
        cmp("clear pulses", 8'(expp), 8'(pulses));
        $display("lock test done");
        reset = 1;
        repeat (2) @(negedge clk);
        reset = 0;
        check_defaults();
        give_verdict();
    end
endmodule
`default_nettype wire
